// File: design/ssp_line_sync.sv
// Pin synchronisers and Start/Stop/edge detection for the serial lines
module ssp_line_sync (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic [2:0] strap_in,
    output logic scl,
    output logic sda,
    output logic [2:0] strap,
    output logic scl_rise,
    output logic scl_fall,
    output logic start_det,
    output logic stop_det
);

    // ------------------------------------------------------------------
    // Two-stage synchronisers, then one history stage for edges
    // ------------------------------------------------------------------
    logic [4:0] meta;
    logic [4:0] sync;
    logic scl_prev;
    logic sda_prev;

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta <= 5'h1f;
            sync <= 5'h1f;
            scl_prev <= 1'b1;
            sda_prev <= 1'b1;
        end
        else
        begin
            meta <= {strap_in, scl_in, sda_in};
            sync <= meta;
            scl_prev <= sync[1];
            sda_prev <= sync[0];
        end
    end

    assign scl = sync[1];
    assign sda = sync[0];
    assign strap = sync[4:2];
    assign scl_rise = scl & ~scl_prev;
    assign scl_fall = ~scl & scl_prev;
    // Clock must be high in both samples so a data change around a clock edge is ignored
    assign start_det = scl & scl_prev & sda_prev & ~sda; // R1
    assign stop_det = scl & scl_prev & ~sda_prev & sda; // R2

endmodule // ssp_line_sync

// File: design/ssp_pkg.sv
// Shared constants and types of the SMBus sensor slave port
package ssp_pkg;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int unsigned CLK_FREQ_HZ = 100_000_000;
    localparam int unsigned TOUT_MS = 25;
    localparam int unsigned TOUT_CYCLES = TOUT_MS * (CLK_FREQ_HZ / 1000);

    // ------------------------------------------------------------------
    // Addressing and framing
    // ------------------------------------------------------------------
    localparam logic [3:0] ADDR_FIXED = 4'h3;
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam logic [2:0] BIT_FIRST = 3'h0;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] PTR_RST = 8'h00;
    localparam logic [15:0] WDATA_RST = 16'h0000;
    localparam logic [7:0] SHREG_RST = 8'h00;
    localparam logic [31:0] TOCNT_RST = 32'h0000_0000;

    // ------------------------------------------------------------------
    // Write byte position within a transaction
    // ------------------------------------------------------------------
    localparam logic [1:0] IDX_PTR = 2'h0;
    localparam logic [1:0] IDX_MSB = 2'h1;
    localparam logic [1:0] IDX_LSB = 2'h2;

    typedef enum logic [6:0] {
        SSP_IDLE     = 7'b000_0001,
        SSP_ADDR     = 7'b000_0010,
        SSP_ADDR_ACK = 7'b000_0100,
        SSP_WR_BYTE  = 7'b000_1000,
        SSP_WR_ACK   = 7'b001_0000,
        SSP_RD_BYTE  = 7'b010_0000,
        SSP_RD_ACK   = 7'b100_0000
    } ssp_state_t;

endpackage

// File: design/ssp_slave_port.sv
// SMBus / standard-mode I2C slave port of a memory-module temperature sensor
// Functional notes
// R1: Data falling while clock high is Start
// R2: Data rising while clock high is Stop
// R3: Start mid-transfer restarts the transaction
// R4: Stop mid-transfer releases data line at once
// R5: Master sends address byte after each Start
// R6: Address is 0011 plus three strap pins
// R7: Acknowledge address only on exact match
// R8: Last address bit: 1 read, 0 write
// R9: Acknowledge every received byte after match
// R10: Master ends with Stop or repeated Start
// R11: Register pointer never auto-increments
// R12: Pointer kept across transactions for reads
// R13: Slave never drives clock nor starts traffic
// R14: Data changes only while clock low
// R15: Busy between Start and Stop, else idle
// R16: Master NAKs last read byte ending data
// R17: Clock stuck beyond timeout resets interface
// R18: First write byte is pointer, then MSB-first
module ssp_slave_port #(
    parameter int unsigned TIMEOUT_CYCLES = ssp_pkg::TOUT_CYCLES
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic addr_strap_bit2,
    input wire logic addr_strap_bit1,
    input wire logic addr_strap_bit0,
    input wire logic [15:0] rd_data,
    output logic [7:0] reg_ptr,
    output logic [15:0] wr_data,
    output logic wr_strobe,
    output logic end_of_read_signal,
    output logic bus_busy
);

    // ------------------------------------------------------------------
    // Line sampling
    // ------------------------------------------------------------------
    logic scl;
    logic sda;
    logic [2:0] strap;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;

    ssp_line_sync u_sync (
        .clock(clock),
        .rst_n(rst_n),
        .scl_in(scl_in),
        .sda_in(sda_in),
        .strap_in({addr_strap_bit2, addr_strap_bit1, addr_strap_bit0}),
        .scl(scl),
        .sda(sda),
        .strap(strap),
        .scl_rise(scl_rise),
        .scl_fall(scl_fall),
        .start_det(start_det),
        .stop_det(stop_det)
    );

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    ssp_pkg::ssp_state_t state;
    ssp_pkg::ssp_state_t next_state;
    logic [2:0] bitcnt;
    logic [2:0] next_bitcnt;
    logic full;
    logic next_full;
    logic [7:0] shreg;
    logic [7:0] next_shreg;
    logic rw;
    logic next_rw;
    logic [1:0] idx;
    logic [1:0] next_idx;
    logic rd_lsb;
    logic next_rd_lsb;
    logic mack;
    logic next_mack;
    logic [7:0] msb_hold;
    logic [7:0] next_msb_hold;
    logic next_oe;
    logic [7:0] next_ptr;
    logic [15:0] next_wdata;
    logic next_wstb;
    logic next_eor;
    logic next_busy;
    logic [31:0] tocnt;

    function automatic logic [7:0] sel_byte(input logic [15:0] data, input logic lsb);
        sel_byte = lsb ? data[7:0] : data[15:8];
    endfunction

    // ------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------
    wire [6:0] own_addr = {ssp_pkg::ADDR_FIXED, strap}; // R6
    wire addr_match = (shreg[7:1] == own_addr); // R7
    wire rx_shift = scl_rise & ((state == ssp_pkg::SSP_ADDR) | (state == ssp_pkg::SSP_WR_BYTE));
    wire count_bit = scl_rise & ((state == ssp_pkg::SSP_ADDR) | (state == ssp_pkg::SSP_WR_BYTE)
                                 | (state == ssp_pkg::SSP_RD_BYTE));
    wire byte_end = scl_fall & full;
    wire [7:0] first_rd = sel_byte(rd_data, 1'b0);
    wire [7:0] again_rd = sel_byte(rd_data, ~rd_lsb);
    // Clock held in either level while busy counts toward the timeout
    wire timeout = bus_busy & (tocnt == 32'(TIMEOUT_CYCLES - 1)); // R17

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    always_comb
    begin
        next_state = state;
        next_bitcnt = bitcnt;
        next_full = full;
        next_shreg = shreg;
        next_rw = rw;
        next_idx = idx;
        next_rd_lsb = rd_lsb;
        next_mack = mack;
        next_msb_hold = msb_hold;
        next_oe = sda_oe;
        next_ptr = reg_ptr; // R11 R12
        next_wdata = wr_data;
        next_wstb = 1'b0;
        next_eor = 1'b0;
        next_busy = bus_busy;
        if (timeout)
        begin
            next_state = ssp_pkg::SSP_IDLE; // R17
            next_oe = 1'b0;
            next_busy = 1'b0;
            next_full = 1'b0;
        end
        else if (start_det)
        begin
            next_state = ssp_pkg::SSP_ADDR; // R3 R5
            next_bitcnt = ssp_pkg::BIT_FIRST;
            next_full = 1'b0;
            next_oe = 1'b0;
            next_idx = ssp_pkg::IDX_PTR;
            next_busy = 1'b1; // R15
        end
        else if (stop_det)
        begin
            next_state = ssp_pkg::SSP_IDLE;
            next_oe = 1'b0; // R4
            next_busy = 1'b0; // R15
            next_full = 1'b0;
        end
        else
        begin
            if (rx_shift)
            begin
                next_shreg = {shreg[6:0], sda}; // R14
            end
            if (count_bit)
            begin
                next_bitcnt = bitcnt + 3'h1;
                next_full = (bitcnt == ssp_pkg::BIT_LAST);
            end
            // Drive changes happen only on a falling clock edge
            unique case (state)
                ssp_pkg::SSP_IDLE:
                begin
                    next_oe = 1'b0;
                end
                ssp_pkg::SSP_ADDR:
                begin
                    if (byte_end)
                    begin
                        next_full = 1'b0;
                        if (addr_match)
                        begin
                            next_oe = 1'b1; // R7 R9
                            next_rw = shreg[0]; // R8
                            next_state = ssp_pkg::SSP_ADDR_ACK;
                        end
                        else
                        begin
                            next_state = ssp_pkg::SSP_IDLE; // R7
                        end
                    end
                end
                ssp_pkg::SSP_ADDR_ACK:
                begin
                    if (scl_fall)
                    begin
                        next_bitcnt = ssp_pkg::BIT_FIRST;
                        if (rw)
                        begin
                            // Read returns the register last selected
                            next_state = ssp_pkg::SSP_RD_BYTE; // R8 R12
                            next_rd_lsb = 1'b0;
                            next_shreg = first_rd;
                            next_oe = ~first_rd[7]; // R14
                        end
                        else
                        begin
                            next_state = ssp_pkg::SSP_WR_BYTE;
                            next_oe = 1'b0;
                        end
                    end
                end
                ssp_pkg::SSP_WR_BYTE:
                begin
                    if (byte_end)
                    begin
                        next_full = 1'b0;
                        next_oe = 1'b1; // R9
                        next_state = ssp_pkg::SSP_WR_ACK;
                        unique case (idx)
                            ssp_pkg::IDX_PTR:
                            begin
                                next_ptr = shreg; // R18
                                next_idx = ssp_pkg::IDX_MSB;
                            end
                            ssp_pkg::IDX_MSB:
                            begin
                                next_msb_hold = shreg; // R18
                                next_idx = ssp_pkg::IDX_LSB;
                            end
                            default:
                            begin
                                // Further pairs rewrite the same register
                                next_wdata = {msb_hold, shreg}; // R18 R11
                                next_wstb = 1'b1;
                                next_idx = ssp_pkg::IDX_MSB;
                            end
                        endcase
                    end
                end
                ssp_pkg::SSP_WR_ACK:
                begin
                    if (scl_fall)
                    begin
                        next_oe = 1'b0;
                        next_state = ssp_pkg::SSP_WR_BYTE;
                    end
                end
                ssp_pkg::SSP_RD_BYTE:
                begin
                    if (byte_end)
                    begin
                        next_full = 1'b0;
                        next_oe = 1'b0;
                        next_state = ssp_pkg::SSP_RD_ACK;
                    end
                    else if (scl_fall)
                    begin
                        next_shreg = {shreg[6:0], 1'b0};
                        next_oe = ~shreg[6]; // R14
                    end
                end
                ssp_pkg::SSP_RD_ACK:
                begin
                    if (scl_rise)
                    begin
                        next_mack = ~sda;
                    end
                    else if (scl_fall)
                    begin
                        next_bitcnt = ssp_pkg::BIT_FIRST;
                        if (mack)
                        begin
                            next_rd_lsb = ~rd_lsb;
                            next_shreg = again_rd;
                            next_oe = ~again_rd[7];
                            next_state = ssp_pkg::SSP_RD_BYTE;
                        end
                        else
                        begin
                            // Not-acknowledge: leave the line for the master's Stop
                            next_eor = 1'b1; // R16
                            next_oe = 1'b0;
                            next_state = ssp_pkg::SSP_IDLE;
                        end
                    end
                end
                default:
                begin
                    next_state = ssp_pkg::SSP_IDLE;
                    next_oe = 1'b0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Timeout counter, cleared by any clock edge
    // ------------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            tocnt <= ssp_pkg::TOCNT_RST;
        else if (!bus_busy || scl_rise || scl_fall || timeout)
            tocnt <= ssp_pkg::TOCNT_RST;
        else
            tocnt <= tocnt + 32'h0000_0001; // R17
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state <= ssp_pkg::SSP_IDLE;
            bitcnt <= ssp_pkg::BIT_FIRST;
            full <= 1'b0;
            shreg <= ssp_pkg::SHREG_RST;
            rw <= 1'b0;
            idx <= ssp_pkg::IDX_PTR;
            rd_lsb <= 1'b0;
            mack <= 1'b0;
            msb_hold <= ssp_pkg::SHREG_RST;
            sda_oe <= 1'b0;
            sda_out <= 1'b0;
            reg_ptr <= ssp_pkg::PTR_RST;
            wr_data <= ssp_pkg::WDATA_RST;
            wr_strobe <= 1'b0;
            end_of_read_signal <= 1'b0;
            bus_busy <= 1'b0;
        end
        else
        begin
            state <= next_state;
            bitcnt <= next_bitcnt;
            full <= next_full;
            shreg <= next_shreg;
            rw <= next_rw;
            idx <= next_idx;
            rd_lsb <= next_rd_lsb;
            mack <= next_mack;
            msb_hold <= next_msb_hold;
            sda_oe <= next_oe;
            // Open drain: only ever pulls low; clock is never driven
            sda_out <= 1'b0; // R13
            reg_ptr <= next_ptr;
            wr_data <= next_wdata;
            wr_strobe <= next_wstb;
            end_of_read_signal <= next_eor;
            bus_busy <= next_busy;
        end
    end

endmodule // ssp_slave_port

// File: tb/smbus_sensor_slave_port_tb.sv
// Self-checking bench for the slave port against a bit-banging master
module smbus_sensor_slave_port_tb;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int unsigned TOUT = 2000;
    logic clock;
    logic rst_n;
    logic [2:0] strap;
    logic scl;
    logic m_low;
    logic sda_oe;
    logic sda_out;
    wire sda_line;
    logic [7:0] reg_ptr;
    logic [15:0] wr_data;
    logic [15:0] rd_data;
    logic wr_strobe;
    logic eor;
    logic bus_busy;
    int fails = 0;
    int comparisons = 0;
    int n_wr = 0;
    int n_eor = 0;
    // Pull-up wins unless someone pulls low; an enabled device shows its output value
    assign sda_line = !m_low && !(sda_oe && !sda_out);
    assign rd_data = {reg_ptr ^ 8'hc3, reg_ptr};
    ssp_slave_port #(
        .TIMEOUT_CYCLES(TOUT)
    ) ssp_slave_port_inst (
        .clock(clock),
        .rst_n(rst_n),
        .scl_in(scl),
        .sda_in(sda_line),
        .sda_out(sda_out),
        .sda_oe(sda_oe),
        .addr_strap_bit2(strap[2]),
        .addr_strap_bit1(strap[1]),
        .addr_strap_bit0(strap[0]),
        .rd_data(rd_data),
        .reg_ptr(reg_ptr),
        .wr_data(wr_data),
        .wr_strobe(wr_strobe),
        .end_of_read_signal(eor),
        .bus_busy(bus_busy)
    );
    ssp_master_model ssp_master_model_inst (
        .clock(clock),
        .sda(sda_line),
        .scl(scl),
        .sda_low(m_low)
    );
    initial
    begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    always @(posedge clock)
    begin
        n_wr <= n_wr + int'(wr_strobe === 1'b1);
        n_eor <= n_eor + int'(eor === 1'b1);
    end
    // ----
    // Helpers
    // ----
    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
        comparisons++;
        if (seen !== exp)
        begin
            fails++;
            $display("MISMATCH at %0t: %s", $time, msg);
        end
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic wb(input logic [7:0] d, input logic exp, input string msg);
        logic a;
        ssp_master_model_inst.wbyte(d, a);
        check(16'(a), 16'(exp), msg);
    endtask
    task automatic rb(input logic last, input logic [7:0] exp, input string msg);
        logic [7:0] d;
        ssp_master_model_inst.rbyte(last, d);
        check(16'(d), 16'(exp), msg);
    endtask
    // ----
    // Scenarios
    // ----
    task automatic t_write();
        int base;
        base = n_wr;
        ssp_master_model_inst.start();
        wb({4'h3, 3'b101, 1'b0}, 1'b1, "strap address ack");
        check(16'(bus_busy), 16'h0001, "busy in transfer");
        wb(8'h05, 1'b1, "pointer ack");
        wb(8'h12, 1'b1, "msb ack");
        wb(8'h34, 1'b1, "lsb ack");
        ssp_master_model_inst.stop();
        check(16'(reg_ptr), 16'h0005, "pointer loaded");
        check(wr_data, 16'h1234, "word msb first");
        check(16'(n_wr - base), 16'h0001, "one word written");
        check(16'(bus_busy), 16'h0000, "idle after stop");
    endtask
    task automatic t_read();
        int base;
        strap = 3'b010;
        base = n_eor;
        ssp_master_model_inst.start();
        wb(8'h35, 1'b1, "read address ack");
        rb(1'b0, 8'hc6, "first byte msb");
        rb(1'b0, 8'h05, "second byte lsb");
        rb(1'b1, 8'hc6, "msb again");
        ssp_master_model_inst.start();
        check(16'(n_eor - base), 16'h0001, "end of read once");
        wb(8'h35, 1'b1, "repeated start ack");
        rb(1'b1, 8'hc6, "re-read same register");
        ssp_master_model_inst.stop();
        check(16'(bus_busy), 16'h0000, "idle after read");
    endtask
    task automatic t_mismatch();
        logic [6:0] bad [5] = '{7'h1b, 7'h18, 7'h1e, 7'h0a, 7'h5a};
        foreach (bad[i])
        begin
            ssp_master_model_inst.start();
            wb({bad[i], 1'b0}, 1'b0, "foreign address ignored");
            wb(8'h0f, 1'b0, "silent after mismatch");
            ssp_master_model_inst.stop();
        end
        check(16'(reg_ptr), 16'h0005, "pointer untouched");
    endtask
    task automatic t_restart();
        int base;
        base = n_wr;
        ssp_master_model_inst.start();
        wb(8'h34, 1'b1, "write address ack");
        wb(8'h07, 1'b1, "pointer ack");
        wb(8'hab, 1'b1, "msb ack");
        ssp_master_model_inst.start();
        wb(8'h34, 1'b1, "address after restart");
        wb(8'h09, 1'b1, "new pointer ack");
        wb(8'h56, 1'b1, "msb ack");
        wb(8'h78, 1'b1, "lsb ack");
        wb(8'h9a, 1'b1, "odd byte ack");
        ssp_master_model_inst.stop();
        check(16'(reg_ptr), 16'h0009, "pointer of fresh transfer");
        check(wr_data, 16'h5678, "half word dropped");
        check(16'(n_wr - base), 16'h0001, "one word only");
    endtask
    // Stop while the device sends a released bit; later clocks must find the line free
    task automatic t_stop_mid();
        logic r;
        ssp_master_model_inst.start();
        wb(8'h35, 1'b1, "read address ack");
        ssp_master_model_inst.bit_io(1'b1, r);
        check(16'(r), 16'h0001, "first read bit");
        ssp_master_model_inst.stop();
        ssp_master_model_inst.bit_io(1'b1, r);
        ssp_master_model_inst.bit_io(1'b1, r);
        check({14'h0, bus_busy, r}, 16'h0001, "line left after stop");
    endtask
    // Clock stalls low while the device holds its acknowledge
    task automatic t_timeout();
        logic r;
        logic [7:0] adr;
        adr = 8'h34;
        ssp_master_model_inst.start();
        for (int i = 7; i >= 0; i--)
            ssp_master_model_inst.bit_io(adr[i], r);
        repeat (8) @(posedge clock);
        #1;
        check(16'(sda_oe), 16'h0001, "ack held with clock low");
        repeat (TOUT + 20) @(posedge clock);
        #1;
        check({14'h0, bus_busy, sda_oe}, 16'h0000, "released on stuck clock");
        ssp_master_model_inst.start();
        wb(8'h34, 1'b1, "ack after timeout");
        ssp_master_model_inst.stop();
    endtask
    initial
    begin
        #200_000;
        fails++;
        tally_and_finish();
    end
    initial
    begin
        rst_n = 1'b0;
        strap = 3'b101;
        repeat (5) @(posedge clock);
        #1;
        rst_n = 1'b1;
        repeat (10) @(posedge clock);
        #1;
        check(16'(reg_ptr), 16'h0000, "pointer at reset");
        check({14'h0, bus_busy, sda_oe}, 16'h0000, "idle at reset");
        t_write();
        t_read();
        t_mismatch();
        t_restart();
        t_stop_mid();
        t_timeout();
        tally_and_finish();
    end
endmodule // smbus_sensor_slave_port_tb

// File: tb/ssp_master_model.sv
// Bit-banging bus master that owns the serial clock
module ssp_master_model (
    input wire logic clock,
    input wire logic sda,
    output logic scl,
    output logic sda_low
);
    timeunit 1ns;
    timeprecision 100ps;
    // ----
    // Bus phases
    // ----
    // Only this side drives the clock; it stands still between frames
    initial
    begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    task automatic wt(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic start();
        wt(4);
        sda_low = 1'b0;
        wt(4);
        scl = 1'b1;
        wt(8);
        sda_low = 1'b1;
        wt(8);
        scl = 1'b0;
    endtask
    task automatic stop();
        wt(4);
        sda_low = 1'b1;
        wt(4);
        scl = 1'b1;
        wt(8);
        sda_low = 1'b0;
        wt(8);
    endtask
    // Data moves a quarter period after the fall, well clear of the rise
    task automatic bit_io(input logic b, output logic r);
        wt(4);
        sda_low = !b;
        wt(4);
        scl = 1'b1;
        wt(8);
        r = sda;
        scl = 1'b0;
    endtask
    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_io(d[i], r);
        bit_io(1'b1, r);
        ack = !r;
    endtask
    task automatic rbyte(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_io(1'b1, d[i]);
        bit_io(last, r);
    endtask
endmodule // ssp_master_model

// File: tb/ssp_slave_port_sva.sv
// Concurrent checks on the slave port pins
module ssp_slave_port_sva #(
    parameter int unsigned TIMEOUT_CYCLES = 2000
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic addr_strap_bit2,
    input wire logic addr_strap_bit1,
    input wire logic addr_strap_bit0,
    input wire logic [15:0] rd_data,
    input wire logic [7:0] reg_ptr,
    input wire logic [15:0] wr_data,
    input wire logic wr_strobe,
    input wire logic end_of_read_signal,
    input wire logic bus_busy
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);
    // ----
    // Stuck clock counter
    // ----
    // Data activity restarts it too, so a Start after long idle never looks stuck
    int unsigned still;
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            still <= 0;
        else if ($changed(scl_in) || $changed(sda_in))
            still <= 0;
        else
            still <= still + 1;
    end
    a_start_busy: assert property (
        scl_in && $past(scl_in) && $fell(sda_in) |-> ##[2:5] bus_busy)
        else $error("Start left the bus idle");
    a_stop_free: assert property (
        scl_in && $past(scl_in) && $rose(sda_in) |-> ##[2:5] (!bus_busy && !sda_oe))
        else $error("Stop did not free the bus");
    a_oe_scl_low: assert property ($changed(sda_oe) && bus_busy |-> !scl_in)
        else $error("Data drive changed while clock high");
    a_pin_open_drain: assert property (sda_out == 1'b0)
        else $error("Data pin driven high");
    a_strobe_ack: assert property (wr_strobe |-> $rose(sda_oe) && bus_busy)
        else $error("Word written without acknowledge");
    a_strobe_once: assert property (wr_strobe |=> !wr_strobe)
        else $error("Write strobe longer than one cycle");
    a_ptr_ack: assert property ($changed(reg_ptr) |-> $rose(sda_oe))
        else $error("Pointer moved outside an acknowledged byte");
    a_eor_free: assert property (
        end_of_read_signal |-> !sda_oe ##1 !end_of_read_signal)
        else $error("End of read with data line held");
    a_tout_free: assert property (still > TIMEOUT_CYCLES + 8 |-> !bus_busy && !sda_oe)
        else $error("Stuck clock did not release the bus");
endmodule // ssp_slave_port_sva

bind ssp_slave_port ssp_slave_port_sva #(
    .TIMEOUT_CYCLES(TIMEOUT_CYCLES)
) ssp_slave_port_sva_inst (
    .clock(clock),
    .rst_n(rst_n),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .sda_out(sda_out),
    .sda_oe(sda_oe),
    .addr_strap_bit2(addr_strap_bit2),
    .addr_strap_bit1(addr_strap_bit1),
    .addr_strap_bit0(addr_strap_bit0),
    .rd_data(rd_data),
    .reg_ptr(reg_ptr),
    .wr_data(wr_data),
    .wr_strobe(wr_strobe),
    .end_of_read_signal(end_of_read_signal),
    .bus_busy(bus_busy)
);
